/* File: rtl/twsi_core.sv */
// Two-wire serial bus interface: APB registers, byte engine, master clock.
// Assumes pins are synchronous to pclk and pulled high outside the chip.
`timescale 1ns/1ps
`default_nettype none
module twsi_core
   import twsi_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pwrite,
   input  wire logic [7:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   input  wire logic       cpu_irq_mask,
   output logic            irq,
   input  wire logic       port_pin_hi_in,
   output logic            port_pin_hi_out,
   output logic            port_pin_hi_oe,
   input  wire logic       port_pin_lo_in,
   output logic            port_pin_lo_out,
   output logic            port_pin_lo_oe,
   input  wire logic       port_dir_hi,
   input  wire logic       port_dir_lo,
   input  wire logic       port_data_hi,
   input  wire logic       port_data_lo
);
   // ---------------------------------------------
   // State
   // ---------------------------------------------
   logic [7:0]  own_reg;
   logic [7:0]  div_reg;
   logic [7:0]  ctl_reg;
   logic [7:0]  tx_reg;
   logic [7:0]  rx_reg;
   logic [31:0] prdata_reg;
   logic [12:0] cnt_reg;
   logic [3:0]  bit_reg;
   mstate_t     state_reg;
   logic        pend_reg;
   logic        arb_reg;
   logic        done_reg;
   logic        addressed_reg;
   logic        busy_reg;
   logic        srw_reg;
   logic        nak_reg;
   logic        armed_reg;
   logic        aphase_reg;
   logic        hold_reg;
   logic        sda_low_reg;
   logic        scl_low_reg;
   logic        scl_q_reg;
   logic        sda_q_reg;
   logic        sda_low_next;
   logic        scl_low_next;

   // ---------------------------------------------
   // Decode
   // ---------------------------------------------
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == OFS_OWN_ADDR) || (a == OFS_DIVIDER) ||
                (a == OFS_CONTROL) || (a == OFS_STATUS) || (a == OFS_DATA);
   endfunction : addr_ok

   logic        en, ms, dir, ackd, hand;
   logic        setup, wr, rd;
   logic        scl_in, sda_in, rise, fall, start_det, stop_det;
   logic        master, tx_mode, byte_done, arb_lose, addr_hit, go_start;
   logic [12:0] half;

   assign en       = ctl_reg[CTL_EN];
   assign ms       = ctl_reg[CTL_MS];
   assign dir      = ctl_reg[CTL_DIR];
   assign ackd     = ctl_reg[CTL_ACKD];
   assign hand     = ctl_reg[CTL_HAND];
   assign setup    = psel & ~penable;
   assign wr       = psel & penable & pwrite;
   assign rd       = psel & penable & ~pwrite;
   assign half     = divider_of(div_reg[4:0]) >> 1;
   // Bus lines read idle high while the pins belong to the port
   assign scl_in   = port_pin_hi_in | ~hand;
   assign sda_in   = port_pin_lo_in | ~hand;
   assign rise     = scl_in & ~scl_q_reg;
   assign fall     = ~scl_in & scl_q_reg;
   assign start_det = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
   assign stop_det = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
   assign master   = (state_reg != M_IDLE);
   assign tx_mode  = dir & (master | addressed_reg);
   assign byte_done = fall & armed_reg & (bit_reg == BIT_ACK);
   // Own one read back as zero while sending
   assign arb_lose = rise & master & tx_mode & (bit_reg < BIT_ACK) &
                     tx_reg[7] & ~sda_in;
   // Address complete at the eighth fall
   assign addr_hit = fall & armed_reg & (bit_reg == 4'h7) & aphase_reg & ~master &
                     (rx_reg[7:1] == own_reg[7:1]);
   assign go_start = en & ms & (state_reg == M_IDLE) & ~busy_reg;

   // ---------------------------------------------
   // APB slave
   // ---------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok(paddr);
   assign prdata  = prdata_reg;

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup & ~pwrite) begin
         if (paddr == OFS_OWN_ADDR) begin
            prdata_reg <= {24'h00_0000, own_reg};
         end else if (paddr == OFS_DIVIDER) begin
            prdata_reg <= {24'h00_0000, div_reg};
         end else if (paddr == OFS_CONTROL) begin
            prdata_reg <= {24'h00_0000, ctl_reg};
         end else if (paddr == OFS_STATUS) begin
            prdata_reg <= {24'h00_0000, done_reg, addressed_reg, busy_reg,
                           arb_reg, 1'b0, srw_reg, pend_reg, nak_reg};
         end else if (paddr == OFS_DATA) begin
            prdata_reg <= {24'h00_0000, rx_reg};
         end else begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   // Own address and divider registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         own_reg <= RST_ZERO;
         div_reg <= RST_ZERO;
      end else if (wr) begin
         if (paddr == OFS_OWN_ADDR) begin
            own_reg <= {pwdata[7:1], 1'b0};
         end else if (paddr == OFS_DIVIDER) begin
            div_reg <= {3'h0, pwdata[4:0]};
         end
      end
   end

   // Control; master select drops on lost arbitration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= RST_ZERO;
      end else if (arb_lose) begin
         ctl_reg[CTL_MS] <= 1'b0;
      end else if (wr && paddr == OFS_CONTROL) begin
         ctl_reg <= en ? pwdata[7:0] : (pwdata[7:0] & CTL_OFF_MASK);
      end
   end

   // Interrupt request
   assign irq = ctl_reg[CTL_IE] & pend_reg & ~cpu_irq_mask;

   // ---------------------------------------------
   // Status flags; a set beats a clear
   // ---------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= 1'b0;
         arb_reg  <= 1'b0;
         done_reg <= 1'b1;
      end else if (!en) begin
         pend_reg <= 1'b0;
         arb_reg  <= 1'b0;
         done_reg <= 1'b1;
      end else begin
         if (byte_done & (master | addressed_reg) | addr_hit | arb_lose) begin
            pend_reg <= 1'b1;
         end else if (wr && paddr == OFS_STATUS && !pwdata[ST_PEND]) begin
            pend_reg <= 1'b0;
         end
         if (arb_lose) begin
            arb_reg <= 1'b1;
         end else if (wr && paddr == OFS_STATUS && !pwdata[ST_ARB]) begin
            arb_reg <= 1'b0;
         end
         if (byte_done) begin
            done_reg <= 1'b1;
         end else if ((wr | rd) && paddr == OFS_DATA) begin
            done_reg <= 1'b0;
         end
      end
   end

   // Bus busy, slave addressing and latched R/W
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg      <= 1'b0;
         addressed_reg <= 1'b0;
         srw_reg       <= 1'b0;
         nak_reg       <= 1'b1;
      end else if (!en) begin
         busy_reg      <= 1'b0;
         addressed_reg <= 1'b0;
         nak_reg       <= 1'b1;
      end else begin
         if (start_det) begin
            busy_reg <= 1'b1;
         end else if (stop_det) begin
            busy_reg <= 1'b0;
         end
         if (start_det | stop_det | arb_lose & 1'b0) begin
            addressed_reg <= 1'b0;
         end else if (addr_hit) begin
            addressed_reg <= 1'b1;
            srw_reg       <= rx_reg[0];
         end else if (rise && bit_reg == BIT_ACK && addressed_reg && dir && sda_in) begin
            addressed_reg <= 1'b0;
         end else if (wr && paddr == OFS_CONTROL && !pwdata[CTL_MS] && !master) begin
            addressed_reg <= addressed_reg;
         end
         if (rise && bit_reg == BIT_ACK) begin
            nak_reg <= sda_in;
         end
      end
   end

   // ---------------------------------------------
   // Byte engine: bits counted from bus edges
   // ---------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q_reg  <= 1'b1;
         sda_q_reg  <= 1'b1;
         bit_reg    <= 4'h0;
         armed_reg  <= 1'b0;
         aphase_reg <= 1'b0;
         rx_reg     <= RST_ZERO;
      end else begin
         scl_q_reg <= scl_in;
         sda_q_reg <= sda_in;
         if (!en || start_det) begin
            bit_reg    <= 4'h0;
            armed_reg  <= 1'b0;
            aphase_reg <= en;
         end else if (stop_det) begin
            aphase_reg <= 1'b0;
            armed_reg  <= 1'b0;
         end else if (rise) begin
            armed_reg <= 1'b1;
            if (bit_reg < BIT_ACK) begin
               rx_reg <= {rx_reg[6:0], sda_in};
            end
         end else if (fall && armed_reg) begin
            armed_reg <= 1'b0;
            if (bit_reg == BIT_ACK) begin
               bit_reg    <= 4'h0;
               aphase_reg <= 1'b0;
            end else begin
               bit_reg <= bit_reg + 4'h1;
            end
         end
      end
   end

   // Transmit shifter, loaded by a data write, advanced at each SCL fall before the acknowledge slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_reg <= 8'hff;
      end else if (wr && paddr == OFS_DATA) begin
         tx_reg <= pwdata[7:0];
      end else if (fall && armed_reg && bit_reg < BIT_ACK) begin
         tx_reg <= {tx_reg[6:0], 1'b1};
      end
   end

   // Hold SCL between bytes until software moves data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= 1'b0;
      end else if (!en) begin
         hold_reg <= 1'b0;
      end else if (go_start | byte_done & (master | addressed_reg) | addr_hit & 1'b0) begin
         hold_reg <= 1'b1;
      end else if ((wr | rd) && paddr == OFS_DATA) begin
         hold_reg <= 1'b0;
      end else if (stop_det) begin
         hold_reg <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Master clock generator
   // ---------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= M_IDLE;
         cnt_reg   <= 13'h0000;
      end else if (!en || arb_lose) begin
         state_reg <= M_IDLE;
         cnt_reg   <= 13'h0000;
      end else begin
         if (cnt_reg != 13'h0000) begin
            cnt_reg <= cnt_reg - 13'h0001;
         end
         case (state_reg)
            M_IDLE: begin
               if (go_start) begin
                  state_reg <= M_START;
                  cnt_reg   <= half;
               end
            end
            M_START: begin
               if (cnt_reg == 13'h0000) begin
                  state_reg <= M_LOW;
                  // Two cycles of pin and edge lag per phase keep the bit at the full divider
                  cnt_reg   <= half - 13'h0002;
               end
            end
            M_LOW: begin
               if (cnt_reg == 13'h0000) begin
                  if (!ms) begin
                     state_reg <= M_STOP_LO;
                     cnt_reg   <= half;
                  end else if (!hold_reg) begin
                     state_reg <= M_WAIT_HI;
                  end
               end
            end
            M_WAIT_HI: begin
               if (scl_in) begin
                  state_reg <= M_HIGH;
                  cnt_reg   <= half - 13'h0002;
               end
            end
            M_HIGH: begin
               if (fall || cnt_reg == 13'h0000) begin
                  state_reg <= M_LOW;
                  cnt_reg   <= half - 13'h0002;
               end
            end
            M_STOP_LO: begin
               if (ms) begin
                  state_reg <= M_RS_HI;
                  cnt_reg   <= half;
               end else if (cnt_reg == 13'h0000) begin
                  state_reg <= M_STOP_HI;
                  cnt_reg   <= half;
               end
            end
            M_RS_HI: begin
               if (!scl_in) begin
                  cnt_reg <= half;
               end else if (cnt_reg == 13'h0000) begin
                  state_reg <= M_START;
                  cnt_reg   <= half;
               end
            end
            M_STOP_HI: begin
               if (!scl_in) begin
                  cnt_reg <= half;
               end else if (cnt_reg == 13'h0000) begin
                  state_reg <= M_IDLE;
               end
            end
            default: state_reg <= M_IDLE;
         endcase
      end
   end

   // ---------------------------------------------
   // Line drive
   // ---------------------------------------------
   always_comb begin
      scl_low_next = (state_reg == M_LOW) | (state_reg == M_STOP_LO) |
                     (addressed_reg & hold_reg);
      sda_low_next = 1'b0;
      if (state_reg == M_START || state_reg == M_STOP_LO || state_reg == M_STOP_HI) begin
         sda_low_next = 1'b1;
      end else if (state_reg == M_RS_HI) begin
         sda_low_next = 1'b0;
      end else if (bit_reg < BIT_ACK) begin
         sda_low_next = tx_mode & ~tx_reg[7] & ~(addressed_reg & aphase_reg);
      end else if (aphase_reg) begin
         sda_low_next = addressed_reg & ~master;
      end else begin
         sda_low_next = ~dir & ~ackd & (master | addressed_reg);
      end
      if (!en) begin
         scl_low_next = 1'b0;
         sda_low_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_low_reg <= 1'b0;
         sda_low_reg <= 1'b0;
      end else begin
         scl_low_reg <= scl_low_next;
         sda_low_reg <= sda_low_next;
      end
   end

   // Pins as open-collector lines or plain port pins
   assign port_pin_hi_out = hand ? 1'b0 : port_data_hi;
   assign port_pin_hi_oe  = hand ? scl_low_reg : port_dir_hi;
   assign port_pin_lo_out = hand ? 1'b0 : port_data_lo;
   assign port_pin_lo_oe  = hand ? sda_low_reg : port_dir_lo;

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_start_drive;
      (state_reg == M_START) ##1 (sda_low_reg && !scl_low_reg);
   endsequence

   a_irq_gate: assert property (irq |-> (pend_reg && ctl_reg[CTL_IE] && !cpu_irq_mask))
      else $error("interrupt without its enable or pending flag");
   a_sda_hold_high: assert property ((state_reg == M_HIGH) ##1 (state_reg == M_HIGH)
      |-> $stable(sda_low_reg))
      else $error("data line moved while clock high");
   a_arb_drop: assert property (arb_lose |=> (state_reg == M_IDLE && !ms && arb_reg && pend_reg))
      else $error("lost arbitration not handled");
   a_start_begin: assert property (go_start |=> s_start_drive)
      else $error("start not driven");
   a_stop_on_clear: assert property ((state_reg == M_LOW && cnt_reg == 13'h0000 && !ms)
      |=> (state_reg == M_STOP_LO) ##1 sda_low_reg)
      else $error("no stop after master select cleared");
   a_rs_no_stop: assert property ((state_reg == M_STOP_LO && ms) |=> (state_reg == M_RS_HI))
      else $error("repeated start not taken");
   a_stretch_wait: assert property ((state_reg == M_WAIT_HI && !scl_in) |=> (state_reg == M_WAIT_HI))
      else $error("clock advanced while held low");
   a_byte_pend: assert property ((byte_done && master && en) |=> (pend_reg && done_reg))
      else $error("byte end did not raise pending");
   a_div_base: assert property ((div_reg[4:0] == 5'h00) |-> (half == 13'h000b))
      else $error("divider base wrong");
   a_pin_port: assert property (!hand |-> (port_pin_lo_oe == port_dir_lo))
      else $error("pins not returned to port");
endmodule : twsi_core
`default_nettype wire

/* File: inc/twsi_pkg.sv */
// Constants, state type and divider decode for the two-wire serial bus block.
// Assumes an APB master on pclk (25 MHz) and pull-ups on both bus lines.
package twsi_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
   localparam logic [7:0] OFS_DIVIDER  = 8'h04;
   localparam logic [7:0] OFS_CONTROL  = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0c;
   localparam logic [7:0] OFS_DATA     = 8'h10;
   // Reset value and control write mask while disabled
   localparam logic [7:0] RST_ZERO     = 8'h00;
   localparam logic [7:0] CTL_OFF_MASK = 8'h84;
   // Control bit positions
   localparam int CTL_EN   = 7;
   localparam int CTL_IE   = 6;
   localparam int CTL_MS   = 5;
   localparam int CTL_DIR  = 4;
   localparam int CTL_ACKD = 3;
   localparam int CTL_HAND = 2;
   // Status bit positions
   localparam int ST_DONE  = 7;
   localparam int ST_ADDR  = 6;
   localparam int ST_BUSY  = 5;
   localparam int ST_ARB   = 4;
   localparam int ST_SRW   = 2;
   localparam int ST_PEND  = 1;
   localparam int ST_NAK   = 0;
   // Bit counter value of the acknowledge slot
   localparam logic [3:0] BIT_ACK = 4'h8;

   typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_WAIT_HI, M_HIGH,
                             M_RS_HI, M_STOP_LO, M_STOP_HI} mstate_t;

   // Bit clock divider from the five-bit code
   function automatic logic [12:0] divider_of(input logic [4:0] code);
      logic [12:0] base;
      base = 13'h016;
      case (code[1:0])
         2'h0: base = 13'h016;
         2'h1: base = 13'h018;
         2'h2: base = 13'h01c;
         default: base = 13'h022;
      endcase
      divider_of = base << code[4:2];
   endfunction : divider_of
endpackage : twsi_pkg

/* File: test/twsi_partner.sv */
// Behavioural slave on the two bus lines: takes bytes, acknowledges its address.
// Assumes wired-AND lines with pull-ups, sampled on pclk.
`timescale 1ns/1ps
`default_nettype none
module twsi_partner #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input  wire logic       pclk,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       stretch,
   output logic            sda_pull,
   output logic            scl_pull,
   output logic [7:0]      rx_byte,
   output logic            got_stop
);
   logic       scl_q, sda_q, first;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic [8:0] tmr;
   initial begin
      {scl_q, sda_q, first, sda_pull, scl_pull, got_stop} = 6'h38;
      {cnt, sh, rx_byte, tmr} = 0;
   end
   // Start, stop, bit shift, acknowledge and stretch
   always @(posedge pclk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
         cnt <= 0;
         first <= 1;
         got_stop <= 0;
      end
      if (scl && scl_q && !sda_q && sda) got_stop <= 1;
      if (scl && !scl_q && cnt < 8) begin
         sh <= {sh[6:0], sda};
         cnt <= cnt + 4'h1;
      end
      if (!scl && scl_q && cnt == 8) begin
         sda_pull <= !first || sh[7:1] == ADDR;
         cnt <= 9;
      end
      if (!scl && scl_q && cnt == 9) begin
         sda_pull <= 0;
         cnt <= 0;
         rx_byte <= sh;
         first <= 0;
         scl_pull <= stretch;
         tmr <= 9'h12c;
      end
      if (tmr != 0) tmr <= tmr - 9'h1;
      if (tmr == 1) scl_pull <= 0;
   end
endmodule : twsi_partner
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench: APB register tests and master transfers to the partner.
// Assumes the core answers APB with pready high in each access cycle.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import twsi_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, err, mask = 0, irq, stretch = 0;
   logic        hi_out, hi_oe, lo_out, lo_oe, dir_lo = 0, dat_lo = 1, scl, sda, spull, cpull, stop;
   logic [7:0]  rx;
   int          mismatches = 0, checks = 0, cyc = 0, t0, per;
   // Wired-AND bus lines with pull-ups
   assign scl = !((hi_oe && !hi_out) || cpull);
   assign sda = !((lo_oe && !lo_out) || spull);
   always #20 pclk = !pclk;
   twsi_core twsi_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_irq_mask(mask), .irq(irq), .port_pin_hi_in(scl), .port_pin_hi_out(hi_out), .port_pin_hi_oe(hi_oe),
      .port_pin_lo_in(sda), .port_pin_lo_out(lo_out), .port_pin_lo_oe(lo_oe), .port_dir_hi(1'b0),
      .port_dir_lo(dir_lo), .port_data_hi(1'b1), .port_data_lo(dat_lo));
   twsi_partner twsi_partner_i (.pclk(pclk), .scl(scl), .sda(sda), .stretch(stretch), .sda_pull(spull),
      .scl_pull(cpull), .rx_byte(rx), .got_stop(stop));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : check
   // One APB transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic wait_pend();
      int i;
      for (i = 0; i < 400; i++) begin
         apb(0, OFS_STATUS, 0);
         if (rd[ST_PEND] === 1'b1) break;
      end
   endtask : wait_pend
   always @(posedge pclk) if (++cyc > 40000) begin
      mismatches++;
      print_verdict();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      apb(0, OFS_OWN_ADDR, 0); check("own", rd, 0);
      apb(0, OFS_DIVIDER, 0); check("div", rd, 0);
      apb(0, OFS_CONTROL, 0); check("ctl", rd, 0);
      apb(0, OFS_STATUS, 0); check("stat", rd, 32'h81);
      apb(0, 8'h14, 0); check("unmapped", err, 1);
      apb(1, OFS_CONTROL, 32'h7c); apb(0, OFS_CONTROL, 0); check("ctl off", rd, 32'h04);
      apb(1, OFS_CONTROL, 0); dir_lo <= 1; dat_lo <= 0; @(posedge pclk); @(negedge pclk);
      check("port oe", lo_oe, 1); check("port out", lo_out, 0);
      dir_lo <= 0; dat_lo <= 1;
      apb(1, OFS_DIVIDER, 32'h1f); apb(0, OFS_DIVIDER, 0); check("div rw", rd, 32'h1f);
      apb(1, OFS_DIVIDER, 0); apb(1, OFS_OWN_ADDR, 32'ha4); apb(0, OFS_OWN_ADDR, 0); check("own rw", rd, 32'ha4);
      apb(1, OFS_CONTROL, 32'h84); apb(1, OFS_CONTROL, 32'hf4);
      apb(1, OFS_DATA, 32'h54);
      @(posedge scl); t0 = cyc; @(posedge scl); per = cyc - t0;
      check("bit period", per >= 22 && per <= 24, 1);
      wait_pend(); check("addr rx", rx, 8'h54); check("ack", rd[ST_NAK], 0);
      check("irq", irq, 1); mask <= 1; @(posedge pclk); @(negedge pclk); check("irq mask", irq, 0);
      mask <= 0; apb(1, OFS_STATUS, 0); @(negedge pclk);
      check("irq clr", irq, 0);
      stretch <= 1; apb(1, OFS_DATA, 32'hc3); wait_pend(); stretch <= 0;
      check("data rx", rx, 8'hc3); check("data ack", rd[ST_NAK], 0);
      apb(1, OFS_STATUS, 0); apb(1, OFS_CONTROL, 32'hd4); apb(1, OFS_CONTROL, 32'hf4);
      apb(1, OFS_DATA, 32'h66); wait_pend();
      check("nak", rd[ST_NAK], 1); check("no stop", stop, 0);
      apb(1, OFS_STATUS, 0); apb(1, OFS_CONTROL, 32'hd4); repeat (200) @(posedge pclk);
      check("stop", stop, 1); apb(0, OFS_STATUS, 0); check("idle", rd[ST_BUSY], 0);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
